// ---- spd_power_ctrl.sv ----
// Power-down, re-init and output-enable control of a 10-bit serializer and
// deserializer pair. Assumes framing logic on core_clk_in supplies the
// boundary lock flag and recovered word; control pins are asynchronous.
// Function
// R1: The deserializer sleeps only when power-down and receiver enable are both low.
// R2: The serializer sleeps whenever its power-down input is low.
// R3: In sleep each side stops its PLL and floats all its outputs, lock included.
// R4: The host wakes a side by holding power-down high for as long as it wants operation.
// R5: After sleep both sides re-initialise; serializer init lasts 1026 cycles.
// R6: On wake the deserializer holds lock indicator high until it has lock.
// R7: The serial pins float while driver enable is low and drive while it is high.
// R8: On driver enable returning, the serializer resumes if other controls stayed static.
// R9: Awake with receiver enable low, recovered word and clock float.
// R10: With receiver outputs disabled the lock indicator stays driven and current.
// R11: Awake, enabled but unlocked, word and clock float and lock indicator is high.
// R12: Locked and enabled, the recovered clock runs with the selected strobe edge.
// R13: An undriven serial input forces the lock indicator high to avoid false lock.
// R14: The lock indicator goes low once the PLL has locked.
// R15: The host holds power-down low at least 16 ns to start a power-down; the code needs it low at two successive rising core_clk_in edges.
// R16: Asynchronous control inputs are synchronised before use.
module spd_power_ctrl #(
   parameter int WORD_W = spd_pkg::WORD_W
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic sleep_request_n_in,
   input wire logic serial_driver_enable_in,
   input wire logic receiver_output_enable_alt_in,
   input wire logic sync_request_a_in,
   input wire logic sync_request_b_in,
   input wire logic transmit_edge_select_in,
   input wire logic recovered_edge_select_in,
   input wire logic line_undriven_in,
   input wire logic [WORD_W-1:0] parallel_input_word_in,
   input wire logic boundary_locked_in,
   input wire logic [WORD_W-1:0] recovered_data_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   output logic irq_out,
   output logic serial_pos_out,
   output logic serial_neg_out,
   output logic serial_oe_out,
   output logic ser_pll_run_out,
   output logic des_pll_run_out,
   output logic [WORD_W-1:0] recovered_word_out,
   output logic recovered_word_oe_out,
   output logic recovered_clock_out,
   output logic recovered_clock_oe_out,
   output logic lock_indicator_out,
   output logic lock_indicator_oe_out
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [spd_pkg::PIN_W-1:0] pins_raw;
   logic [spd_pkg::PIN_W-1:0] pin_s1_reg;
   logic [spd_pkg::PIN_W-1:0] pin_s2_reg;
   logic [spd_pkg::PIN_W-1:0] pin_s3_reg;
   logic [spd_pkg::PIN_W-1:0] pin_f_reg;

   assign pins_raw = {line_undriven_in, recovered_edge_select_in, transmit_edge_select_in,
                      sync_request_b_in, sync_request_a_in, receiver_output_enable_alt_in,
                      serial_driver_enable_in, sleep_request_n_in};

   // Four flops per pin; a level counts once stages two and three agree
   for (genvar i = 0; i < spd_pkg::PIN_W; i++) begin : g_pin
      always_ff @(posedge core_clk_in or posedge reset_in) begin
         if (reset_in) begin
            pin_s1_reg[i] <= spd_pkg::PINS_RESET[i];
            pin_s2_reg[i] <= spd_pkg::PINS_RESET[i];
            pin_s3_reg[i] <= spd_pkg::PINS_RESET[i];
            pin_f_reg[i] <= spd_pkg::PINS_RESET[i];
         end else begin
            pin_s1_reg[i] <= pins_raw[i];
            pin_s2_reg[i] <= pin_s1_reg[i];
            pin_s3_reg[i] <= pin_s2_reg[i];
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_f_reg[i] <= pin_s3_reg[i]; // R16
            end
         end
      end
   end

   logic sleep_n;
   logic drv_en;
   logic roe;
   logic undriven;
   logic des_sleep;
   assign sleep_n = pin_f_reg[spd_pkg::PIN_SLEEP_N];
   assign drv_en = pin_f_reg[spd_pkg::PIN_DRV_EN];
   assign roe = pin_f_reg[spd_pkg::PIN_ROE];
   assign undriven = pin_f_reg[spd_pkg::PIN_UNDRIVEN];
   assign des_sleep = !sleep_n && !roe; // R1

   // ************************************************************
   // Serializer sequencing
   // ************************************************************
   spd_pkg::spd_ser_state_e ser_state_reg, ser_state_next;
   logic [10:0] ser_cnt_reg;
   logic [3:0] ctrl_snap_reg;
   logic ctrl_changed_reg;
   logic drv_en_d_reg;
   logic [3:0] ctrl_now;
   logic resume_bad;

   assign ctrl_now = {pin_f_reg[spd_pkg::PIN_TX_EDGE], sleep_n,
                      pin_f_reg[spd_pkg::PIN_SYNC_B], pin_f_reg[spd_pkg::PIN_SYNC_A]};
   // A change of sleep, sync A/B or transmit edge select during float forces a fresh init on resume
   assign resume_bad = drv_en && !drv_en_d_reg && ctrl_changed_reg;

   // Next serializer state
   always_comb begin
      ser_state_next = ser_state_reg;
      case (ser_state_reg)
         spd_pkg::SER_SLEEP: ser_state_next = spd_pkg::SER_INIT; // R4
         spd_pkg::SER_INIT: begin
            if (ser_cnt_reg == spd_pkg::SER_INIT_CYCLES - 11'h001) begin
               ser_state_next = spd_pkg::SER_RUN; // R5
            end
         end
         spd_pkg::SER_RUN: begin
            if (resume_bad) begin
               ser_state_next = spd_pkg::SER_INIT; // R8
            end
         end
         default: ser_state_next = spd_pkg::SER_SLEEP;
      endcase
      if (!sleep_n) begin
         ser_state_next = spd_pkg::SER_SLEEP; // R2
      end
   end

   // State, init counter and held-control tracking
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ser_state_reg <= spd_pkg::SER_SLEEP;
         ser_cnt_reg <= 11'h000;
         ctrl_snap_reg <= 4'h0;
         ctrl_changed_reg <= 1'b0;
         drv_en_d_reg <= 1'b0;
      end else begin
         ser_state_reg <= ser_state_next;
         drv_en_d_reg <= drv_en;
         if (ser_state_next == spd_pkg::SER_INIT && ser_state_reg == spd_pkg::SER_INIT) begin
            ser_cnt_reg <= ser_cnt_reg + 11'h001;
         end else begin
            ser_cnt_reg <= 11'h000;
         end
         if (drv_en) begin
            ctrl_snap_reg <= ctrl_now;
            ctrl_changed_reg <= 1'b0;
         end else if (ctrl_now != ctrl_snap_reg) begin
            ctrl_changed_reg <= 1'b1; // R8
         end
      end
   end

   // ************************************************************
   // Serial frame and driver enable
   // ************************************************************
   logic [11:0] frame_reg;
   logic [3:0] bit_cnt_reg;

   // Start high, ten data bits, stop low; shifted out LSB first
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         frame_reg <= 12'h000;
         bit_cnt_reg <= 4'h0;
         serial_pos_out <= 1'b0;
         serial_neg_out <= 1'b1;
         serial_oe_out <= 1'b0;
         ser_pll_run_out <= 1'b0;
      end else begin
         if (bit_cnt_reg == spd_pkg::FRAME_LAST) begin
            bit_cnt_reg <= 4'h0;
            frame_reg <= {1'b0, parallel_input_word_in, 1'b1};
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            frame_reg <= {1'b0, frame_reg[11:1]};
         end
         serial_pos_out <= frame_reg[0];
         serial_neg_out <= !frame_reg[0];
         serial_oe_out <= drv_en && ser_state_next != spd_pkg::SER_SLEEP; // R7 R3
         ser_pll_run_out <= ser_state_next != spd_pkg::SER_SLEEP; // R3
      end
   end

   // ************************************************************
   // Deserializer lock and outputs
   // ************************************************************
   spd_pkg::spd_des_state_e des_state_reg, des_state_next;
   logic live_lock;
   logic out_en;
   assign live_lock = boundary_locked_in && !undriven; // R13

   // Next deserializer state
   always_comb begin
      des_state_next = des_state_reg;
      case (des_state_reg)
         spd_pkg::DES_SLEEP: des_state_next = spd_pkg::DES_ACQUIRE; // R5
         spd_pkg::DES_ACQUIRE: begin
            if (live_lock) begin
               des_state_next = spd_pkg::DES_LOCKED; // R14
            end
         end
         spd_pkg::DES_LOCKED: begin
            if (!live_lock) begin
               des_state_next = spd_pkg::DES_ACQUIRE; // R13
            end
         end
         default: des_state_next = spd_pkg::DES_SLEEP;
      endcase
      if (des_sleep) begin
         des_state_next = spd_pkg::DES_SLEEP; // R1
      end
   end
   assign out_en = des_state_next == spd_pkg::DES_LOCKED && roe;

   // Registered pin values; data changes opposite the chosen strobe edge
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         des_state_reg <= spd_pkg::DES_SLEEP;
         lock_indicator_out <= 1'b1;
         lock_indicator_oe_out <= 1'b0;
         des_pll_run_out <= 1'b0;
         recovered_word_oe_out <= 1'b0;
         recovered_clock_oe_out <= 1'b0;
         recovered_clock_out <= 1'b0;
         recovered_word_out <= '0;
      end else begin
         des_state_reg <= des_state_next;
         lock_indicator_out <= des_state_next != spd_pkg::DES_LOCKED; // R6 R14
         lock_indicator_oe_out <= des_state_next != spd_pkg::DES_SLEEP; // R3 R10
         des_pll_run_out <= des_state_next != spd_pkg::DES_SLEEP; // R3
         recovered_word_oe_out <= out_en; // R9 R11
         recovered_clock_oe_out <= out_en; // R9 R11
         if (out_en) begin
            recovered_clock_out <= !recovered_clock_out; // R12
            if (recovered_clock_out == pin_f_reg[spd_pkg::PIN_RX_EDGE]) begin
               recovered_word_out <= recovered_data_in; // R12
            end
         end else begin
            recovered_clock_out <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Event status, mask and register port
   // ************************************************************
   logic [spd_pkg::EV_W-1:0] status_reg;
   logic [spd_pkg::EV_W-1:0] mask_reg;
   logic [spd_pkg::EV_W-1:0] ev_set;
   logic [spd_pkg::EV_W-1:0] ev_clr;
   logic undriven_d_reg;

   always_comb begin
      ev_set = '0;
      ev_set[spd_pkg::EV_LOCK_GAINED] = des_state_next == spd_pkg::DES_LOCKED &&
                                        des_state_reg != spd_pkg::DES_LOCKED;
      ev_set[spd_pkg::EV_LOCK_LOST] = des_state_reg == spd_pkg::DES_LOCKED &&
                                      des_state_next != spd_pkg::DES_LOCKED;
      ev_set[spd_pkg::EV_INIT_DONE] = ser_state_next == spd_pkg::SER_RUN &&
                                      ser_state_reg == spd_pkg::SER_INIT;
      ev_set[spd_pkg::EV_FAILSAFE] = undriven && !undriven_d_reg;
      ev_clr = '0;
      if (reg_write_in && reg_addr_in == spd_pkg::ADDR_STATUS) begin
         ev_clr = reg_wdata_in[spd_pkg::EV_W-1:0];
      end
   end

   // Sticky status; a new event beats a same-cycle clear
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         status_reg <= '0;
         mask_reg <= spd_pkg::MASK_RESET;
         undriven_d_reg <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         undriven_d_reg <= undriven;
         status_reg <= (status_reg & ~ev_clr) | ev_set;
         if (reg_write_in && reg_addr_in == spd_pkg::ADDR_MASK) begin
            mask_reg <= reg_wdata_in[spd_pkg::EV_W-1:0];
         end
         irq_out <= |(((status_reg & ~ev_clr) | ev_set) & mask_reg);
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         reg_rdata_out <= 32'h0000_0000;
         if (reg_read_in) begin
            case (reg_addr_in)
               spd_pkg::ADDR_STATUS: reg_rdata_out[spd_pkg::EV_W-1:0] <= status_reg;
               spd_pkg::ADDR_MASK: reg_rdata_out[spd_pkg::EV_W-1:0] <= mask_reg;
               spd_pkg::ADDR_STATE: begin
                  reg_rdata_out[spd_pkg::ST_SER_SLEEP] <= ser_state_reg == spd_pkg::SER_SLEEP;
                  reg_rdata_out[spd_pkg::ST_SER_INIT] <= ser_state_reg == spd_pkg::SER_INIT;
                  reg_rdata_out[spd_pkg::ST_DES_SLEEP] <= des_state_reg == spd_pkg::DES_SLEEP;
                  reg_rdata_out[spd_pkg::ST_DES_LOCKED] <= des_state_reg == spd_pkg::DES_LOCKED;
                  reg_rdata_out[spd_pkg::ST_LOCK_IND] <= lock_indicator_out;
                  reg_rdata_out[spd_pkg::ST_UNDRIVEN] <= undriven;
               end
               default: reg_rdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   a_ser_sleep_float: assert property (!sleep_n |=> !serial_oe_out && !ser_pll_run_out) // R2
      else $error("serializer not asleep");
   a_des_sleep_float: assert property (des_sleep |=> !lock_indicator_oe_out &&
      !recovered_word_oe_out && !recovered_clock_oe_out && !des_pll_run_out) // R3
      else $error("deserializer outputs not floating");
   a_des_needs_both: assert property (!sleep_n && roe |=> des_pll_run_out) // R1
      else $error("deserializer slept with receiver enable high");
   a_driver_float: assert property (!drv_en |=> !serial_oe_out) // R7
      else $error("serial driver active while disabled");
   a_init_length: assert property ($rose(ser_state_reg == spd_pkg::SER_RUN) |->
      $past(ser_cnt_reg) == spd_pkg::SER_INIT_CYCLES - 11'h001) // R5
      else $error("serializer init length wrong");
   a_acquire_high: assert property (des_state_reg == spd_pkg::DES_ACQUIRE |->
      lock_indicator_out && !recovered_word_oe_out && !recovered_clock_oe_out) // R6
      else $error("outputs live before lock");
   a_lock_goes_low: assert property (des_state_reg == spd_pkg::DES_ACQUIRE && live_lock &&
      !des_sleep |=> !lock_indicator_out) // R14
      else $error("lock indicator did not fall");
   a_failsafe_high: assert property (undriven |=> lock_indicator_out) // R13
      else $error("lock indicator low on undriven line");
   a_rx_disabled: assert property (sleep_n && !roe |=> lock_indicator_oe_out &&
      !recovered_word_oe_out && !recovered_clock_oe_out) // R10
      else $error("receiver disable handling wrong");
   a_rclk_running: assert property (recovered_clock_oe_out && $past(recovered_clock_oe_out)
      |-> recovered_clock_out != $past(recovered_clock_out)) // R12
      else $error("recovered clock stalled");
   a_strobe_phase: assert property ($changed(recovered_word_out) && recovered_word_oe_out
      |-> recovered_clock_out != $past(pin_f_reg[spd_pkg::PIN_RX_EDGE])) // R12
      else $error("recovered word changed on the wrong clock edge");
   a_resume_state: assert property (drv_en && !drv_en_d_reg && !ctrl_changed_reg &&
      sleep_n && ser_state_reg == spd_pkg::SER_RUN |=> ser_state_reg == spd_pkg::SER_RUN) // R8
      else $error("serializer did not resume");
   a_sync_agree: assert property ($changed(pin_f_reg) |->
      ((pin_f_reg ^ $past(pin_f_reg)) & ($past(pin_s2_reg) ^ $past(pin_s3_reg))) == '0) // R16
      else $error("pin taken before stages agreed");

   c_lock_gained: cover property (status_reg[spd_pkg::EV_LOCK_GAINED]);
   c_init_done: cover property ($rose(ser_state_reg == spd_pkg::SER_RUN));
   c_des_sleep: cover property ($rose(des_state_reg == spd_pkg::DES_SLEEP));
   c_resume: cover property (drv_en && !drv_en_d_reg && ser_state_reg == spd_pkg::SER_RUN);
endmodule

// ---- spd_pkg.sv ----
// Shared constants for the serdes power-down and output control block.
// Assumes one 20 MHz core clock and the plain register port of spd_power_ctrl.
package spd_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam logic [10:0] SER_INIT_CYCLES = 11'h402; // Serializer init length
   localparam logic [3:0] FRAME_LAST = 4'hB; // Twelve bits per serial frame
   localparam int WORD_W = 10;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_MASK = 8'h04;
   localparam logic [7:0] ADDR_STATE = 8'h08;
   localparam logic [3:0] MASK_RESET = 4'h0;
   // Event bits of status and mask
   localparam int EV_LOCK_GAINED = 0;
   localparam int EV_LOCK_LOST = 1;
   localparam int EV_INIT_DONE = 2;
   localparam int EV_FAILSAFE = 3;
   localparam int EV_W = 4;
   // State register bits
   localparam int ST_SER_SLEEP = 0;
   localparam int ST_SER_INIT = 1;
   localparam int ST_DES_SLEEP = 2;
   localparam int ST_DES_LOCKED = 3;
   localparam int ST_LOCK_IND = 4;
   localparam int ST_UNDRIVEN = 5;
   // ************************************************************
   // Pin vector layout
   // ************************************************************
   localparam int PIN_SLEEP_N = 0;
   localparam int PIN_DRV_EN = 1;
   localparam int PIN_ROE = 2;
   localparam int PIN_SYNC_A = 3;
   localparam int PIN_SYNC_B = 4;
   localparam int PIN_TX_EDGE = 5;
   localparam int PIN_RX_EDGE = 6;
   localparam int PIN_UNDRIVEN = 7;
   localparam int PIN_W = 8;
   localparam logic [7:0] PINS_RESET = 8'h00;
   // ************************************************************
   // States
   // ************************************************************
   typedef enum logic [1:0] {SER_SLEEP, SER_INIT, SER_RUN} spd_ser_state_e;
   typedef enum logic [1:0] {DES_SLEEP, DES_ACQUIRE, DES_LOCKED} spd_des_state_e;
endpackage

// ---- spd_peer_model.sv ----
// Far-side peer model: framing lock and recovered word seen by the block.
// Assumes the core clock and a bench that says when the peer transmits.
module spd_peer_model (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic transmit_in,
   output logic boundary_locked_out,
   output logic [spd_pkg::WORD_W-1:0] recovered_data_out
);
   // ************************************************************
   // Boundary hunt and recovered word
   // ************************************************************
   localparam logic [9:0] PEER_WORD = 10'h2B5;
   logic [2:0] hunt_reg;
   // Lock only after four boundaries in a row, as slow as the real peer
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         hunt_reg <= 3'h0;
      end else if (!transmit_in) begin
         hunt_reg <= 3'h0;
      end else if (hunt_reg != 3'h4) begin
         hunt_reg <= hunt_reg + 3'h1;
      end
   end
   assign boundary_locked_out = (hunt_reg == 3'h4);
   // Unlocked word toggles each cycle so a stale value never holds for two cycles in a row
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         recovered_data_out <= 10'h000;
      end else if (boundary_locked_out) begin
         recovered_data_out <= PEER_WORD;
      end else begin
         recovered_data_out <= ~recovered_data_out;
      end
   end
endmodule

// ---- tb.sv ----
// Self-checking bench for spd_power_ctrl with the peer model on its far side.
// Assumes a 20 MHz core clock and the plain one-cycle register port.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic core_clk_in = 1'b0, reset_in = 1'b0, sleep_n = 1'b0, serial_driver_enable = 1'b0, roe = 1'b0;
   logic sync_a = 1'b0, und = 1'b0, tx = 1'b0, redge = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
   logic sync_b = 1'b0, txe = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic irq_out, s_pos, s_neg, s_oe, s_pll, d_pll, w_oe, c_out, c_oe, l_out, l_oe, blk;
   logic [9:0] word, rdat;
   int fails = 0, tests_run = 0, cyc = 0, n;
   logic [18:0] rows [7] = '{
      {5'b11100, 7'b1110011, 7'b1111111}, // Awake, unlocked
      {5'b11101, 7'b1111110, 7'b1111111}, // Locked, all driven
      {5'b11001, 7'b1110010, 7'b1111111}, // Receiver outputs off
      {5'b10101, 7'b0111110, 7'b1111111}, // Driver off
      {5'b11111, 7'b1110011, 7'b1111111}, // Undriven line
      {5'b01101, 7'b0011110, 7'b1111111}, // Serializer only asleep
      {5'b01001, 7'b0000000, 7'b1111110}}; // Both asleep
   spd_power_ctrl u_spd_power_ctrl (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .sleep_request_n_in(sleep_n), .serial_driver_enable_in(serial_driver_enable),
      .receiver_output_enable_alt_in(roe), .sync_request_a_in(sync_a),
      .sync_request_b_in(sync_b), .transmit_edge_select_in(txe),
      .recovered_edge_select_in(redge), .line_undriven_in(und),
      .parallel_input_word_in(10'h155), .boundary_locked_in(blk),
      .recovered_data_in(rdat), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata), .irq_out(irq_out),
      .serial_pos_out(s_pos), .serial_neg_out(s_neg), .serial_oe_out(s_oe),
      .ser_pll_run_out(s_pll), .des_pll_run_out(d_pll), .recovered_word_out(word),
      .recovered_word_oe_out(w_oe), .recovered_clock_out(c_out),
      .recovered_clock_oe_out(c_oe), .lock_indicator_out(l_out),
      .lock_indicator_oe_out(l_oe));
   spd_peer_model u_spd_peer_model (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .transmit_in(tx), .boundary_locked_out(blk), .recovered_data_out(rdat));
   // ************************************************************
   // Clock, timeout and tasks
   // ************************************************************
   always #25 core_clk_in = ~core_clk_in;
   // Ceiling well above the longest init wait
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         conclude();
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk_in);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge core_clk_in);
      wr_s <= 1'b0;
   endtask
   // Data stands only in the cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge core_clk_in);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   function automatic logic [6:0] pins();
      return {s_oe, s_pll, d_pll, w_oe, c_oe, l_oe, l_out};
   endfunction
   task automatic chk_pins(input string nm, input logic [6:0] e, g, m);
      tests_run++;
      if ((g & m) !== (e & m)) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", nm, e & m, g & m);
      end
   endtask
   task automatic chk_reg(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      // Raise reset as a real edge so the asynchronous branch runs at once
      reset_in <= 1'b1;
      tick(2);
      #1 chk_pins("reset_pins", 7'b0000001, pins(), 7'h7F);
      tick(1);
      reset_in <= 1'b0;
      rd(spd_pkg::ADDR_MASK, d);
      chk_reg("mask_reset", 32'h0, d);
      $display("test reset done");
      // Table of pin settings against the expected output state
      for (int i = 0; i < 7; i++) begin
         {sleep_n, serial_driver_enable, roe, und, tx} <= rows[i][18:14];
         tick(8);
         #1 chk_pins("row_pins", rows[i][13:7], pins(), rows[i][6:0]);
      end
      $display("test table done");
      // Lock gained, lock lost and fail-safe rise were all seen by the table
      rd(spd_pkg::ADDR_STATUS, d);
      chk_reg("status_events", 32'hB, d);
      // Wake with only init-done unmasked and time the serializer init
      wr(spd_pkg::ADDR_STATUS, 32'hF);
      wr(spd_pkg::ADDR_MASK, 32'h1 << spd_pkg::EV_INIT_DONE);
      {sleep_n, roe} <= 2'b11;
      n = 0;
      while (s_pll !== 1'b1 && n < 20) begin
         @(posedge core_clk_in);
         #1 n++;
      end
      n = 0;
      while (irq_out !== 1'b1 && n < 1100) begin
         @(posedge core_clk_in);
         #1 n++;
      end
      chk_reg("init_length", {21'h0, spd_pkg::SER_INIT_CYCLES}, n);
      wr(spd_pkg::ADDR_STATUS, 32'h1 << spd_pkg::EV_INIT_DONE);
      tick(2);
      #1 chk_reg("irq_cleared", 32'h0, {31'h0, irq_out});
      rd(spd_pkg::ADDR_MASK, d);
      chk_reg("mask_read", 32'h4, d);
      rd(8'h0C, d);
      chk_reg("unmapped_read", 32'h0, d);
      $display("test init done");
      // Running recovered clock and word under both strobe edges
      for (int e = 0; e < 2; e++) begin
         redge <= e[0];
         tick(4);
         #1 d[0] = c_out;
         tick(1);
         #1 chk_reg("rclk_toggle", {31'h0, ~d[0]}, {31'h0, c_out});
         chk_reg("rword", 32'h2B5, {22'h0, word});
         chk_reg("serial_pair", {31'h0, ~s_pos}, {31'h0, s_neg});
      end
      $display("test recovered done");
      // Driver off and back with static controls resumes run state
      serial_driver_enable <= 1'b0;
      tick(8);
      serial_driver_enable <= 1'b1;
      tick(8);
      rd(spd_pkg::ADDR_STATE, d);
      chk_reg("resume_run", 32'h0, {31'h0, d[spd_pkg::ST_SER_INIT]});
      // A change of sync_a, txe or sync_b while disabled forces a fresh init
      for (int k = 0; k < 3; k++) begin
         // Restart only counts from run, so let the previous init finish
         if (k > 0) begin
            tick(1030);
         end
         serial_driver_enable <= 1'b0;
         tick(2);
         {sync_b, txe, sync_a} <= 3'h1 << k;
         tick(8);
         {sync_b, txe, sync_a} <= 3'h0;
         tick(8);
         serial_driver_enable <= 1'b1;
         tick(8);
         rd(spd_pkg::ADDR_STATE, d);
         chk_reg("restart_init", 32'h1, {31'h0, d[spd_pkg::ST_SER_INIT]});
      end
      $display("test resume done");
      conclude();
   end
endmodule
